// ===== rca_cfg.svh
`ifndef RCA_CFG_SVH
`define RCA_CFG_SVH
// ----------------------------------------
// scheme codes
// ----------------------------------------
`define RCA_SCHEME_ARB 3'h1
`define RCA_SCHEME_PEER_MASTER 3'h2
`define RCA_SCHEME_LOCAL_MASTER 3'h3
`define RCA_SCHEME_TWO_WIRE 3'h4
`define RCA_SCHEME_ALT 3'h5
`define RCA_SCHEME_RST 3'h1
// ----------------------------------------
// policy bits
// ----------------------------------------
`define RCA_POL_VOICE 0
`define RCA_POL_LOCAL_WINS 1
`define RCA_POL_PEER_WINS 2
`define RCA_POL_TDM 3
`define RCA_POL_RST 4'h9
// ----------------------------------------
// timing
// ----------------------------------------
`define RCA_CLK_PERIOD_NS 4
`define RCA_TDM_SLOT_NS 625
`define RCA_TDM_SLOT_CYC ((`RCA_TDM_SLOT_NS + `RCA_CLK_PERIOD_NS - 1) / `RCA_CLK_PERIOD_NS)
`endif

// ===== rca_pkg.sv
package rca_pkg;
	typedef enum logic [2:0] {
		RCA_ARB = 3'h1,
		RCA_PEER_MASTER = 3'h2,
		RCA_LOCAL_MASTER = 3'h3,
		RCA_TWO_WIRE = 3'h4,
		RCA_ALT = 3'h5
	} rca_scheme_type;
	typedef struct packed {
		logic line_one;
		logic line_two;
		logic line_three;
		logic line_four;
	} rca_lines_type;
	typedef struct packed {
		logic valid;
		logic [2:0] scheme;
		logic [3:0] policy_mask;
		logic [3:0] policy_value;
		logic master_is_peer;
	} rca_cmd_type;
	typedef struct packed {
		logic req;
		logic critical;
	} rca_req_type;
endpackage

// ===== rca_sync.sv
module rca_sync (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// lines
	input wire logic [3:0] async_in,
	output logic [3:0] sync_out
);
	logic [3:0] meta_ff;
	logic [3:0] sync_ff;
	// ----------------------------------------
	// two-stage synchroniser per line
	// ----------------------------------------
	genvar i;
	generate
		for (i = 0; i < 4; i = i + 1) begin : g_line
			always_ff @(posedge clk_sys or negedge rst_n) begin
				if (!rst_n) begin
					meta_ff[i] <= 1'b0;
					sync_ff[i] <= 1'b0;
				end else begin
					meta_ff[i] <= async_in[i];
					sync_ff[i] <= meta_ff[i];
				end
			end
		end
	endgenerate
	assign sync_out = sync_ff;
endmodule

// ===== rca_tdm_timer.sv
`include "rca_cfg.svh"
module rca_tdm_timer (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// control
	input wire logic run,
	// status
	output logic local_turn
);
	localparam int SLOT_CYC = `RCA_TDM_SLOT_CYC;
	logic [8:0] cnt_ff;
	logic [8:0] nxt_cnt;
	logic turn_ff;
	wire slot_end = (cnt_ff == 9'(SLOT_CYC - 1));
	// ----------------------------------------
	// slot counter alternating the turn
	// ----------------------------------------
	assign nxt_cnt = (!run || slot_end) ? 9'h000 : cnt_ff + 9'h001;
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			cnt_ff <= 9'h000;
			turn_ff <= 1'b1;
		end else begin
			cnt_ff <= nxt_cnt;
			turn_ff <= !run ? 1'b1 : (slot_end ? ~turn_ff : turn_ff);
		end
	end
	assign local_turn = turn_ff;
endmodule

// ===== rca_arbiter.sv
// Operation
// - five schemes by command, scheme one after reset
// - scheme one uses four arbitration lines
// - sole requester gets whole medium
// - critical local links win over peer
// - contention shared by slots plus priority
// - each priority policy switched by command
// - peer inhibit high stops local radio
// - local need drives peer inhibit high
// - two-wire mode, host picks master
// - local uses only reserved beacon portion
// - local windows follow medium-free line
// - lines share pins with other functions
`include "rca_cfg.svh"
module rca_arbiter (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// host command
	input wire rca_pkg::rca_cmd_type cmd,
	// local baseband
	input wire rca_pkg::rca_req_type local_req,
	output logic local_grant,
	// coexistence pins
	input wire rca_pkg::rca_lines_type line_in,
	output rca_pkg::rca_lines_type line_out,
	output rca_pkg::rca_lines_type line_oe,
	// status
	output logic [2:0] scheme_now
);
	import rca_pkg::*;
	// ----------------------------------------
	// configuration held from host commands
	// ----------------------------------------
	logic [2:0] scheme_ff;
	logic [3:0] policy_ff;
	logic peer_master_ff;
	wire cmd_scheme_ok = (cmd.scheme >= `RCA_SCHEME_ARB) && (cmd.scheme <= `RCA_SCHEME_ALT);
	wire [3:0] nxt_policy = (policy_ff & ~cmd.policy_mask) | (cmd.policy_value & cmd.policy_mask);
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			scheme_ff <= `RCA_SCHEME_RST;
			policy_ff <= `RCA_POL_RST;
			peer_master_ff <= 1'b0;
		end else if (cmd.valid) begin
			if (cmd_scheme_ok)
				scheme_ff <= cmd.scheme;
			policy_ff <= nxt_policy;
			peer_master_ff <= cmd.master_is_peer;
		end
	end
	assign scheme_now = scheme_ff;
	// ----------------------------------------
	// synchronised inputs
	// ----------------------------------------
	logic [3:0] sync_lines;
	rca_sync u_sync (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.async_in({line_in.line_one, line_in.line_two, line_in.line_three, line_in.line_four}),
		.sync_out(sync_lines)
	);
	wire s_one = sync_lines[3];
	wire s_three = sync_lines[1];
	wire s_four = sync_lines[0];
	// ----------------------------------------
	// scheme decode
	// ----------------------------------------
	wire m_arb = (scheme_ff == `RCA_SCHEME_ARB);
	wire m_peer = (scheme_ff == `RCA_SCHEME_PEER_MASTER);
	wire m_local = (scheme_ff == `RCA_SCHEME_LOCAL_MASTER);
	wire m_two = (scheme_ff == `RCA_SCHEME_TWO_WIRE);
	wire m_alt = (scheme_ff == `RCA_SCHEME_ALT);
	// ----------------------------------------
	// packet traffic arbitration
	// ----------------------------------------
	// line one in: peer transmit request, line three: peer status (busy),
	// line four: peer high priority; line two out: local grant confirm
	wire peer_req = s_one | s_three;
	wire peer_hi = s_four;
	wire both = local_req.req && peer_req;
	logic tdm_turn;
	rca_tdm_timer u_tdm (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.run(m_arb && both && policy_ff[`RCA_POL_TDM]),
		.local_turn(tdm_turn)
	);
	wire voice_win = policy_ff[`RCA_POL_VOICE] && local_req.critical;
	wire peer_hi_win = policy_ff[`RCA_POL_PEER_WINS] && peer_hi;
	logic arb_grant;
	always_comb begin
		if (!local_req.req)
			arb_grant = 1'b0;
		else if (!peer_req)
			arb_grant = 1'b1;
		else if (voice_win)
			arb_grant = 1'b1;
		else if (peer_hi_win)
			arb_grant = 1'b0;
		else if (policy_ff[`RCA_POL_TDM])
			arb_grant = tdm_turn;
		else
			arb_grant = policy_ff[`RCA_POL_LOCAL_WINS];
	end
	// ----------------------------------------
	// alternating medium access
	// ----------------------------------------
	wire alt_grant = local_req.req && s_one;
	// ----------------------------------------
	// inhibit schemes
	// ----------------------------------------
	wire peer_inhibit_in = s_one;
	wire two_local_grant = peer_master_ff ? !peer_inhibit_in : 1'b1;
	wire two_drive_out = !peer_master_ff && local_req.req;
	logic grant_c;
	always_comb begin
		case (scheme_ff)
			`RCA_SCHEME_ARB: grant_c = arb_grant;
			`RCA_SCHEME_PEER_MASTER: grant_c = local_req.req && !peer_inhibit_in;
			`RCA_SCHEME_LOCAL_MASTER: grant_c = local_req.req;
			`RCA_SCHEME_TWO_WIRE: grant_c = local_req.req && two_local_grant;
			`RCA_SCHEME_ALT: grant_c = alt_grant;
			default: grant_c = 1'b0;
		endcase
	end
	// ----------------------------------------
	// registered outputs
	// ----------------------------------------
	logic grant_ff;
	logic line_two_ff;
	wire nxt_line_two = (m_arb && grant_c) | (m_local && local_req.req) | (m_two && two_drive_out);
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			grant_ff <= 1'b0;
			line_two_ff <= 1'b0;
		end else begin
			grant_ff <= grant_c;
			line_two_ff <= nxt_line_two;
		end
	end
	assign local_grant = grant_ff;
	// ----------------------------------------
	// pin drive; only line two is ever an output, and only in schemes one, three and four
	// ----------------------------------------
	assign line_out = '{line_one: 1'b0, line_two: line_two_ff, line_three: 1'b0, line_four: 1'b0};
	assign line_oe = '{line_one: 1'b0, line_two: (m_arb | m_local | m_two),
		line_three: 1'b0, line_four: 1'b0};
	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	sequence s_peer_block;
		m_peer && peer_inhibit_in;
	endsequence
	chk_peer_inhibit_holds: assert property (s_peer_block |=> !local_grant)
		else $error("grant while peer inhibit high");
	chk_local_inhibit_out: assert property (m_local && local_req.req |=> line_out.line_two)
		else $error("inhibit out not raised");
	chk_sole_request: assert property (m_arb && local_req.req && !peer_req |=> local_grant)
		else $error("sole requester not granted");
	chk_voice_priority: assert property (m_arb && local_req.req && voice_win |=> local_grant)
		else $error("critical link not granted");
	chk_no_collision: assert property (m_arb && local_req.req && peer_req && !voice_win
		&& peer_hi_win |=> !local_grant)
		else $error("grant against high priority peer");
	chk_alt_window: assert property (m_alt && !s_one |=> !local_grant)
		else $error("grant outside medium free window");
	chk_alt_follow: assert property (m_alt && local_req.req && s_one |=> local_grant)
		else $error("grant missing in free window");
	chk_sync_delay: assert property (m_peer && $rose(line_in.line_one) ##1 line_in.line_one
		|-> ##1 peer_inhibit_in)
		else $error("synchroniser latency wrong");
	chk_scheme_load: assert property (cmd.valid && cmd_scheme_ok |=> scheme_ff == $past(cmd.scheme))
		else $error("scheme not loaded");
	chk_two_wire_peer: assert property (m_two && peer_master_ff && peer_inhibit_in
		|=> !local_grant)
		else $error("two-wire grant under peer master");
	chk_policy_load: assert property (cmd.valid |=> policy_ff == $past(nxt_policy))
		else $error("policy not updated");
	chk_line_two_oe: assert property ((m_peer || m_alt) |-> !line_oe.line_two)
		else $error("line two driven when unused");
endmodule

// ===== rca_wlan_model.sv
module rca_wlan_model
	import rca_pkg::*;
(
	// peer intent
	input wire logic peer_one,
	input wire logic peer_busy,
	input wire logic peer_hi,
	// pins
	input wire rca_pkg::rca_lines_type line_out,
	input wire rca_pkg::rca_lines_type line_oe,
	output rca_pkg::rca_lines_type line_in,
	// peer state
	output logic peer_silent
);
	timeunit 1ns;
	timeprecision 1ps;
	// ----------------------------------------
	// peer drives
	// ----------------------------------------
	assign line_in.line_one = peer_one;
	assign line_in.line_two = line_oe.line_two ? line_out.line_two : 1'b1;
	assign line_in.line_three = peer_busy;
	assign line_in.line_four = peer_hi;
	// ----------------------------------------
	// peer stays off air while inhibited
	// ----------------------------------------
	assign peer_silent = line_oe.line_two & line_out.line_two;
endmodule

// ===== test_radio_coexistence_arbiter.sv
module test_radio_coexistence_arbiter;
	timeunit 1ns;
	timeprecision 1ps;
	import rca_pkg::*;
	typedef struct packed {
		logic [2:0] sch;
		logic mp;
		logic req;
		logic crit;
		logic [2:0] peer;
		logic gnt;
		logic two;
	} rca_row_type;
	logic clk_sys, rst_n, local_grant, peer_one, peer_busy, peer_hi, peer_silent;
	rca_cmd_type cmd;
	rca_req_type local_req;
	rca_lines_type line_in, line_out, line_oe;
	logic [2:0] scheme_now;
	int bad_count, checks_done, hi_n, lo_n;
	rca_row_type rows [12] = '{
		'{3'h1, 1'b0, 1'b1, 1'b0, 3'h0, 1'b1, 1'b1},
		'{3'h1, 1'b0, 1'b0, 1'b0, 3'h2, 1'b0, 1'b0},
		'{3'h1, 1'b0, 1'b1, 1'b1, 3'h7, 1'b1, 1'b1},
		'{3'h2, 1'b0, 1'b1, 1'b0, 3'h4, 1'b0, 1'b0},
		'{3'h2, 1'b0, 1'b1, 1'b0, 3'h0, 1'b1, 1'b0},
		'{3'h3, 1'b0, 1'b1, 1'b0, 3'h4, 1'b1, 1'b1},
		'{3'h3, 1'b0, 1'b0, 1'b0, 3'h0, 1'b0, 1'b0},
		'{3'h4, 1'b1, 1'b1, 1'b0, 3'h4, 1'b0, 1'b0},
		'{3'h4, 1'b1, 1'b1, 1'b0, 3'h0, 1'b1, 1'b0},
		'{3'h4, 1'b0, 1'b1, 1'b0, 3'h4, 1'b1, 1'b1},
		'{3'h5, 1'b0, 1'b1, 1'b0, 3'h4, 1'b1, 1'b0},
		'{3'h5, 1'b0, 1'b1, 1'b0, 3'h0, 1'b0, 1'b0}
	};
	// ----------------------------------------
	// design and peer
	// ----------------------------------------
	rca_arbiter DUT (.clk_sys(clk_sys), .rst_n(rst_n), .cmd(cmd), .local_req(local_req),
		.local_grant(local_grant), .line_in(line_in), .line_out(line_out),
		.line_oe(line_oe), .scheme_now(scheme_now));
	rca_wlan_model peer (.peer_one(peer_one), .peer_busy(peer_busy), .peer_hi(peer_hi),
		.line_out(line_out), .line_oe(line_oe), .line_in(line_in), .peer_silent(peer_silent));
	initial begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic chk(input string n, input logic [2:0] e, input logic [2:0] g);
		checks_done++;
		if (g !== e) begin
			bad_count++;
			$display("CHECK FAILED %s expected %0h seen %0h", n, e, g);
		end
	endtask
	task automatic send(input logic [2:0] s, input logic [3:0] m, input logic [3:0] v,
		input logic mp);
		@(negedge clk_sys);
		cmd = '{1'b1, s, m, v, mp};
		@(negedge clk_sys);
		cmd.valid = 1'b0;
	endtask
	task automatic settle();
		repeat (5) @(negedge clk_sys);
	endtask
	task automatic run_row(input rca_row_type r);
		send(r.sch, 4'h0, 4'h0, r.mp);
		local_req = '{r.req, r.crit};
		{peer_one, peer_busy, peer_hi} = r.peer;
		settle();
		chk("scheme_now", r.sch, scheme_now);
		chk("local_grant", {2'b0, r.gnt}, {2'b0, local_grant});
		chk("line_two_out", {2'b0, r.two}, {2'b0, line_out.line_two});
	endtask
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	initial begin
		#100000;
		bad_count++;
		wrap_up();
	end
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		rst_n = 1'b0;
		cmd = '0;
		local_req = '0;
		{peer_one, peer_busy, peer_hi} = 3'h0;
		@(negedge clk_sys);
		chk("reset_scheme", 3'h1, scheme_now);
		chk("reset_grant", 3'h0, {2'b0, local_grant});
		repeat (3) @(negedge clk_sys);
		rst_n = 1'b1;
		foreach (rows[i]) begin
			run_row(rows[i]);
		end
		send(3'h7, 4'h0, 4'h0, 1'b0);
		@(negedge clk_sys);
		chk("refused_scheme", 3'h5, scheme_now);
		send(3'h3, 4'h0, 4'h0, 1'b0);
		local_req = '{1'b1, 1'b0};
		settle();
		chk("peer_silent", 3'h1, {2'b0, peer_silent});
		send(3'h1, 4'hF, 4'h4, 1'b0);
		{peer_one, peer_busy, peer_hi} = 3'h3;
		settle();
		chk("peer_hi_wins", 3'h0, {2'b0, local_grant});
		send(3'h1, 4'hF, 4'h2, 1'b0);
		settle();
		chk("local_wins", 3'h1, {2'b0, local_grant});
		send(3'h1, 4'hF, 4'h8, 1'b0);
		settle();
		repeat (400) begin
			@(negedge clk_sys);
			if (local_grant === 1'b1) hi_n++;
			if (local_grant === 1'b0) lo_n++;
		end
		chk("tdm_split", 3'h1, {2'b0, (hi_n >= 80 && lo_n >= 80)});
		rst_n = 1'b0;
		@(negedge clk_sys);
		chk("rereset_scheme", 3'h1, scheme_now);
		wrap_up();
	end
endmodule
